// ==== atisc_pkg.sv ====
// Package with register map, field layout and timing constants
package atisc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SW_TRIGGER_OFF    = 8'h0c;
  localparam logic [7:0] INPUT_SEL_OFF     = 8'h10;
  localparam logic [7:0] EVENT_ROUTE_OFF   = 8'h14;
  localparam logic [7:0] INT_STATUS_OFF    = 8'h18;
  localparam logic [7:0] INT_MASK_OFF      = 8'h1c;
  localparam logic [7:0] CONV_STATUS_OFF   = 8'h20;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLUSH_BIT       = 0;
  localparam int START_BIT       = 1;
  localparam int GAIN_LSB        = 24;
  localparam int OFFSET_LSB      = 20;
  localparam int SCAN_LSB        = 16;
  localparam int NEG_LSB         = 8;
  localparam int POS_LSB         = 0;
  localparam int START_EI_BIT    = 0;
  localparam int SYNC_EI_BIT     = 1;
  localparam int RESRDY_EO_BIT   = 4;
  localparam int WINMON_EO_BIT   = 5;
  localparam int IRQ_RESRDY_BIT  = 0;
  localparam int IRQ_WINMON_BIT  = 1;
  localparam int IRQ_FLUSH_BIT   = 2;
  localparam int IRQ_BITS        = 3;
  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [31:0] INPUT_SEL_RST   = 32'h0000_0000;
  localparam logic [31:0] INPUT_SEL_MASK  = 32'h0fff_1f1f;
  localparam logic [7:0]  EVENT_ROUTE_RST = 8'h00;
  localparam logic [7:0]  EVENT_ROUTE_MASK = 8'h33;
  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [3:0] GAIN_MAX_CODE  = 4'h4;
  localparam logic [3:0] GAIN_HALF_CODE = 4'hf;
  localparam logic [4:0] POS_PIN_MAX    = 5'h13;
  localparam logic [4:0] POS_INT_MIN    = 5'h18;
  localparam logic [4:0] POS_INT_MAX    = 5'h1c;
  localparam logic [4:0] NEG_PIN_MAX    = 5'h07;
  localparam logic [4:0] NEG_GND        = 5'h18;
  localparam logic [4:0] NEG_IO_GND     = 5'h19;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ      = 100;
  localparam int CONV_DIV_DEFAULT = 4;
  localparam int CONV_TICKS       = 16;
  localparam int DIV_W            = 8;

  typedef enum logic [1:0] {
    ATISC_IDLE  = 2'b00,
    ATISC_CONV  = 2'b01,
    ATISC_FLUSH = 2'b10
  } atisc_state_type;
endpackage

// ==== atisc_clk_div.sv ====
// Converter clock divider with synchronous restart
`timescale 1ns/1ns
`default_nettype none
module atisc_clk_div
  import atisc_pkg::*;
#(
  parameter int DIV = CONV_DIV_DEFAULT
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic clkEn,
  input  wire logic restart,
  output logic      tick
);
  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] nxt_cnt;
  logic             nxt_tick;

  always_comb begin
    nxt_cnt  = cnt_ff + DIV_W'(1);
    nxt_tick = 1'b0;
    if (restart) begin
      nxt_cnt = '0;
    end else if (cnt_ff == DIV_W'(DIV - 1)) begin
      nxt_cnt  = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      tick   <= 1'b0;
    end else if (clkEn) begin
      cnt_ff <= nxt_cnt;
      tick   <= nxt_tick;
    end
  end
endmodule
`default_nettype wire

// ==== atisc_sync2.sv ====
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
`default_nettype none
module atisc_sync2 (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic clkEn,
  input  wire logic din,
  output logic      dout
);
  logic meta_ff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      dout    <= 1'b0;
    end else if (clkEn) begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ==== atisc_top.sv ====
// Conversion trigger, input select and scan control with APB registers
`timescale 1ns/1ns
`default_nettype none
module atisc_top
  import atisc_pkg::*;
#(
  parameter int CONV_DIV = CONV_DIV_DEFAULT
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        startEventIn,
  input  wire logic        syncEventIn,
  input  wire logic        windowDetect,
  output logic             resultReadyEventOut,
  output logic             windowEventOut,
  output logic      [4:0]  positiveChannel,
  output logic      [4:0]  negativeChannel,
  output logic      [3:0]  gainSelect,
  output logic             gainCodeBad,
  output logic             convActive,
  output logic             convDone,
  output logic             irq
);
  import atisc_pkg::*;

  // ----------------------------------------------------------------
  // Event inputs cross into the clock domain
  // ----------------------------------------------------------------
  logic startEvS, syncEvS, winS;
  logic startEvD_ff, syncEvD_ff, winD_ff;
  atisc_sync2 uSyncStart (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn),
                          .din(startEventIn), .dout(startEvS));
  atisc_sync2 uSyncFlush (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn),
                          .din(syncEventIn), .dout(syncEvS));
  atisc_sync2 uSyncWin   (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn),
                          .din(windowDetect), .dout(winS));

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0]         inSel_ff, nxt_inSel;
  logic [7:0]          evRoute_ff, nxt_evRoute;
  logic                start_ff, nxt_start;
  logic                flush_ff, nxt_flush;
  logic [IRQ_BITS-1:0] intStat_ff, nxt_intStat;
  logic [IRQ_BITS-1:0] intMask_ff, nxt_intMask;
  logic [31:0]         nxt_prdata;
  logic                nxt_pready;
  logic                nxt_pslverr;
  atisc_state_type     state_ff, nxt_state;
  logic [4:0]          tickCnt_ff, nxt_tickCnt;
  logic                pending_ff, nxt_pending;
  logic                nxt_done, nxt_resEv, nxt_winEv;
  logic                convTick;

  logic wrAcc, rdAcc, wrBad, startEvt, syncEvt, winEvt, flushReq;
  logic [3:0] offsetFld, scanFld;

  // Writes land at the edge the master sees pready; errors go out with it
  assign wrAcc     = psel & penable & pwrite & pready;
  assign rdAcc     = psel & penable & ~pwrite & ~pready;
  assign wrBad     = psel & penable & pwrite & ~pready &
                     !(paddr inside {SW_TRIGGER_OFF, INPUT_SEL_OFF,
                                     EVENT_ROUTE_OFF, INT_STATUS_OFF,
                                     INT_MASK_OFF});
  assign startEvt  = startEvS & ~startEvD_ff & evRoute_ff[START_EI_BIT];
  assign syncEvt   = syncEvS & ~syncEvD_ff & evRoute_ff[SYNC_EI_BIT];
  assign winEvt    = winS & ~winD_ff;
  assign offsetFld = inSel_ff[OFFSET_LSB +: 4];
  assign scanFld   = inSel_ff[SCAN_LSB +: 4];
  assign flushReq  = flush_ff | syncEvt;

  // Restart on flush so the first tick after it is a full period
  atisc_clk_div #(.DIV(CONV_DIV)) uDiv (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clkEn   (clkEn),
    .restart (state_ff == ATISC_FLUSH),
    .tick    (convTick)
  );

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state   = state_ff;
    nxt_tickCnt = tickCnt_ff;
    nxt_pending = pending_ff | startEvt | syncEvt;
    nxt_done    = 1'b0;
    case (state_ff)
      ATISC_IDLE: begin
        if (flushReq) begin
          nxt_state = ATISC_FLUSH;
        end else if (start_ff | nxt_pending) begin
          nxt_state   = ATISC_CONV;
          nxt_pending = 1'b0;
          nxt_tickCnt = '0;
        end
      end
      ATISC_CONV: begin
        if (flushReq) begin
          nxt_state = ATISC_FLUSH;
        end else if (convTick) begin
          nxt_tickCnt = tickCnt_ff + 5'h01;
          if (tickCnt_ff == 5'(CONV_TICKS - 1)) begin
            nxt_state = ATISC_IDLE;
            nxt_done  = 1'b1;
          end
        end
      end
      ATISC_FLUSH: begin
        // Resume: a pending request converts afresh once flushed
        nxt_state   = ATISC_IDLE;
        nxt_tickCnt = '0;
      end
      default: nxt_state = ATISC_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // APB register access and self-clearing bits
  // ----------------------------------------------------------------
  always_comb begin
    nxt_inSel   = inSel_ff;
    nxt_evRoute = evRoute_ff;
    nxt_start   = start_ff;
    nxt_flush   = flush_ff;
    nxt_intMask = intMask_ff;
    nxt_intStat = intStat_ff;
    nxt_prdata  = prdata;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    if (state_ff == ATISC_IDLE && !flushReq && start_ff) begin
      nxt_start = 1'b0;
    end
    if (state_ff == ATISC_FLUSH) begin
      nxt_flush = 1'b0;
    end
    if (nxt_done) begin
      // Offset wraps inside its field; range is software's job
      nxt_inSel[OFFSET_LSB +: 4] = offsetFld + 4'h1;
    end
    if (wrAcc) begin
      case (paddr)
        SW_TRIGGER_OFF: begin
          if (pwdata[START_BIT] && !start_ff) begin
            nxt_start = 1'b1;
          end
          if (pwdata[FLUSH_BIT]) begin
            nxt_flush = 1'b1;
          end
        end
        INPUT_SEL_OFF:   nxt_inSel   = pwdata & INPUT_SEL_MASK;
        EVENT_ROUTE_OFF: nxt_evRoute = pwdata[7:0] & EVENT_ROUTE_MASK;
        INT_STATUS_OFF:  nxt_intStat = intStat_ff & ~pwdata[IRQ_BITS-1:0];
        INT_MASK_OFF:    nxt_intMask = pwdata[IRQ_BITS-1:0];
        default: begin
        end
      endcase
    end
    if (wrBad) begin
      nxt_pslverr = 1'b1;
    end
    // Hardware set wins over a same-cycle clear
    if (nxt_done) begin
      nxt_intStat[IRQ_RESRDY_BIT] = 1'b1;
    end
    if (winEvt) begin
      nxt_intStat[IRQ_WINMON_BIT] = 1'b1;
    end
    if (state_ff == ATISC_FLUSH) begin
      nxt_intStat[IRQ_FLUSH_BIT] = 1'b1;
    end
    if (rdAcc) begin
      case (paddr)
        SW_TRIGGER_OFF:  nxt_prdata = {30'h0, start_ff, flush_ff};
        INPUT_SEL_OFF:   nxt_prdata = inSel_ff;
        EVENT_ROUTE_OFF: nxt_prdata = {24'h0, evRoute_ff};
        INT_STATUS_OFF:  nxt_prdata = {29'h0, intStat_ff};
        INT_MASK_OFF:    nxt_prdata = {29'h0, intMask_ff};
        CONV_STATUS_OFF: nxt_prdata = {27'h0, pending_ff, tickCnt_ff[3:0] == 4'h0,
                                       state_ff, convActive};
        default: begin
          nxt_prdata  = 32'h0;
          nxt_pslverr = 1'b1;
        end
      endcase
    end
    if (psel & penable & ~pready) begin
      nxt_pready = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Output drive: channel, gain, events
  // ----------------------------------------------------------------
  logic [4:0] nxt_pos;
  logic [3:0] nxt_gain;
  logic       nxt_gainBad;
  always_comb begin
    // Scan count is ignored; channel is base plus offset for any count
    nxt_pos     = inSel_ff[POS_LSB +: 5] +
                  ((scanFld != 4'h0) ? {1'b0, offsetFld} :
                   {1'b0, offsetFld});
    nxt_gain    = inSel_ff[GAIN_LSB +: 4];
    nxt_gainBad = (nxt_gain > GAIN_MAX_CODE) && (nxt_gain != GAIN_HALF_CODE);
    nxt_resEv   = nxt_done & evRoute_ff[RESRDY_EO_BIT];
    nxt_winEv   = winEvt & evRoute_ff[WINMON_EO_BIT];
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      inSel_ff            <= INPUT_SEL_RST;
      evRoute_ff          <= EVENT_ROUTE_RST;
      start_ff            <= 1'b0;
      flush_ff            <= 1'b0;
      intStat_ff          <= '0;
      intMask_ff          <= '0;
      prdata              <= 32'h0;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      state_ff            <= ATISC_IDLE;
      tickCnt_ff          <= '0;
      pending_ff          <= 1'b0;
      startEvD_ff         <= 1'b0;
      syncEvD_ff          <= 1'b0;
      winD_ff             <= 1'b0;
      resultReadyEventOut <= 1'b0;
      windowEventOut      <= 1'b0;
      positiveChannel     <= 5'h00;
      negativeChannel     <= 5'h00;
      gainSelect          <= 4'h0;
      gainCodeBad         <= 1'b0;
      convActive          <= 1'b0;
      convDone            <= 1'b0;
      irq                 <= 1'b0;
    end else if (clkEn) begin
      inSel_ff            <= nxt_inSel;
      evRoute_ff          <= nxt_evRoute;
      start_ff            <= nxt_start;
      flush_ff            <= nxt_flush;
      intStat_ff          <= nxt_intStat;
      intMask_ff          <= nxt_intMask;
      prdata              <= nxt_prdata;
      pready              <= nxt_pready;
      pslverr             <= nxt_pslverr;
      state_ff            <= nxt_state;
      tickCnt_ff          <= nxt_tickCnt;
      pending_ff          <= nxt_pending;
      startEvD_ff         <= startEvS;
      syncEvD_ff          <= syncEvS;
      winD_ff             <= winS;
      resultReadyEventOut <= nxt_resEv;
      windowEventOut      <= nxt_winEv;
      positiveChannel     <= nxt_pos;
      negativeChannel     <= inSel_ff[NEG_LSB +: 5];
      gainSelect          <= nxt_gain;
      gainCodeBad         <= nxt_gainBad;
      convActive          <= (nxt_state == ATISC_CONV);
      convDone            <= nxt_done;
      irq                 <= |(nxt_intStat & nxt_intMask);
    end
  end
endmodule
`default_nettype wire

// ==== atisc_checker.sv ====
// Concurrent checks on the ports of the conversion control block
`timescale 1ns/1ns
`default_nettype none
module atisc_checker
  import atisc_pkg::*;
#(
  parameter int CONV_DIV = CONV_DIV_DEFAULT
) (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        convActive,
  input wire logic        convDone,
  input wire logic [3:0]  gainSelect,
  input wire logic        gainCodeBad,
  input wire logic [4:0]  negativeChannel,
  input wire logic        resultReadyEventOut
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Shadow registers, so checks never trust the read path
  // ----------------------------------------------------------------
  logic       wrTaken;
  logic       swWr;
  logic       selWr;
  logic [7:0] route_ff;
  logic [7:0] nxt_route;
  logic [4:0] neg_ff;
  logic [4:0] nxt_neg;
  assign wrTaken = psel && penable && pready && pwrite;
  assign swWr    = wrTaken && paddr == SW_TRIGGER_OFF;
  assign selWr   = wrTaken && paddr == INPUT_SEL_OFF;
  always_comb begin
    nxt_route = route_ff;
    nxt_neg   = neg_ff;
    if (wrTaken && paddr == EVENT_ROUTE_OFF) begin
      nxt_route = pwdata[7:0];
    end
    if (selWr) begin
      nxt_neg = pwdata[12:8];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      route_ff <= 8'h00;
      neg_ff   <= 5'h00;
    end else begin
      route_ff <= nxt_route;
      neg_ff   <= nxt_neg;
    end
  end
  start_begin_a: assert property (
    swWr && pwdata[1:0] == 2'b10 && !convActive |-> ##[1:4] convActive)
    else $error("start write began no conversion");
  flush_abort_a: assert property (
    swWr && pwdata[0] |-> ##[1:3] !convActive)
    else $error("flush did not stop the conversion");
  flush_nodone_a: assert property (
    swWr && pwdata[0] |=> !convDone [*8])
    else $error("completion seen after flush");
  done_active_a: assert property (
    convDone |-> $past(convActive))
    else $error("completion without active conversion");
  gain_bad_a: assert property (
    $stable(gainSelect) |-> gainCodeBad == (gainSelect inside {[4'h5:4'he]}))
    else $error("reserved gain flag wrong");
  neg_copy_a: assert property (
    selWr |=> ##[0:1] negativeChannel == neg_ff)
    else $error("negative channel not taken from write");
  evout_en_a: assert property (
    resultReadyEventOut |-> route_ff[4] || $past(route_ff[4]))
    else $error("result event while disabled");
  evout_done_a: assert property (
    convDone && route_ff[4] |-> ##[0:1] resultReadyEventOut)
    else $error("result event missing");
  cover property (convDone);
  cover property (swWr && pwdata[0] && convActive);
  cover property (resultReadyEventOut);
endmodule
bind atisc_top atisc_checker #(.CONV_DIV(CONV_DIV)) chk_u (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .convActive(convActive), .convDone(convDone), .gainSelect(gainSelect),
  .gainCodeBad(gainCodeBad), .negativeChannel(negativeChannel),
  .resultReadyEventOut(resultReadyEventOut));
`default_nettype wire

// ==== atisc_front_model.sv ====
// Analog front end model: latches the channel, flags a window hit
`timescale 1ns/1ns
`default_nettype none
module atisc_front_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       convActive,
  input  wire logic [4:0] positiveChannel,
  input  wire logic [4:0] hitChannel,
  output logic      [4:0] seenChan,
  output logic            windowDetect
);
  logic       actPrev;
  logic [2:0] hitCnt;
  // Comparator level drops once the hit has been held four cycles
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      actPrev  <= 1'b0;
      seenChan <= 5'h00;
      hitCnt   <= 3'h0;
    end else begin
      actPrev <= convActive;
      if (convActive && !actPrev) begin
        seenChan <= positiveChannel;
        hitCnt   <= (positiveChannel == hitChannel) ? 3'h4 : 3'h0;
      end else if (hitCnt != 3'h0) begin
        hitCnt <= hitCnt - 3'h1;
      end
    end
  end
  assign windowDetect = hitCnt != 3'h0;
endmodule
`default_nettype wire

// ==== atisc_tb.sv ====
// Self-checking bench for the conversion control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import atisc_pkg::*;
  typedef struct {
    logic [7:0] a; logic [31:0] d; logic [31:0] e; logic x;
  } atisc_row_type;
  logic        sys_clk = 1'b0, rst_b = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, resEv, winEv, winDet, gainBad;
  logic        startEv = 1'b0, syncEv = 1'b0, convActive, convDone, irq;
  logic        clkEn = 1'b1;
  logic [4:0]  posCh, negCh, seenChan;
  logic [3:0]  gainSel;
  logic [4:0]  cv;
  int          err_count = 0, n_compared = 0, n, doneCnt, resCnt, winCnt;
  atisc_row_type rows [4] = '{
    '{8'h10, 32'hffffffff, 32'h0fff1f1f, 1'b0},
    '{8'h14, 32'hffffffff, 32'h00000033, 1'b0},
    '{8'h20, 32'h00000001, 32'h0, 1'b1},
    '{8'h40, 32'h00000001, 32'h0, 1'b1}};
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    doneCnt <= doneCnt + int'(convDone);
    resCnt  <= resCnt + int'(resEv);
    winCnt  <= winCnt + int'(winEv);
  end
  atisc_top #(.CONV_DIV(4)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .startEventIn(startEv), .syncEventIn(syncEv),
    .windowDetect(winDet), .resultReadyEventOut(resEv),
    .windowEventOut(winEv), .positiveChannel(posCh),
    .negativeChannel(negCh), .gainSelect(gainSel), .gainCodeBad(gainBad),
    .convActive(convActive), .convDone(convDone), .irq(irq));
  atisc_front_model fe_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .convActive(convActive), .positiveChannel(posCh),
    .hitChannel(5'h05), .seenChan(seenChan), .windowDetect(winDet));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    // Sample pready at the rising edge, as the slave's flops see it
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      final_report;
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt(input bit done);
    for (n = 0; n < 300 && !(done ? convDone : convActive); n++)
      @(negedge sys_clk);
    if (n == 300) begin
      err_count++;
      final_report;
    end
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].d);
      chk("pslverr", rerr, rows[i].x);
      if (!rows[i].x) apb(rows[i].a, 1'b0, 32'h0);
      if (!rows[i].x) chk("readback", rdat, rows[i].e);
    end
    $display("test rows done");
    for (int c = 0; c < 32; c++) begin
      cv = c[4:0];
      apb(INPUT_SEL_OFF, 1'b1, {4'h0, cv[3:0], 11'h0, cv, 3'h0, cv});
      repeat (2) @(negedge sys_clk);
      chk("pos", posCh, cv);
      chk("neg", negCh, cv);
      chk("gain", gainSel, cv[3:0]);
      chk("bad", gainBad, cv[3:0] inside {[5:14]});
    end
    $display("test codes done");
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(INPUT_SEL_OFF, 1'b0, 32'h0);
    chk("sel reset", rdat, 32'h0);
    apb(EVENT_ROUTE_OFF, 1'b0, 32'h0);
    chk("route reset", rdat, 32'h0);
    apb(EVENT_ROUTE_OFF, 1'b1, 32'h30);
    apb(INPUT_SEL_OFF, 1'b1, 32'h00230003);
    for (int k = 0; k < 2; k++) begin
      apb(SW_TRIGGER_OFF, 1'b1, 32'h2);
      wt(1'b0);
      apb(SW_TRIGGER_OFF, 1'b0, 32'h0);
      chk("start clear", rdat[1], 1'b0);
      wt(1'b1);
      chk("channel", seenChan, 5'(5 + k));
    end
    apb(INPUT_SEL_OFF, 1'b0, 32'h0);
    chk("offset", rdat[23:20], 4'h4);
    chk("res events", resCnt, 2);
    chk("win events", winCnt, 1);
    $display("test scan done");
    apb(SW_TRIGGER_OFF, 1'b1, 32'h0);
    startEv <= 1'b1;
    repeat (100) @(negedge sys_clk);
    chk("no start", doneCnt, 2);
    apb(SW_TRIGGER_OFF, 1'b1, 32'h2);
    wt(1'b0);
    repeat (10) @(negedge sys_clk);
    apb(SW_TRIGGER_OFF, 1'b1, 32'h1);
    repeat (100) @(negedge sys_clk);
    chk("flush done", doneCnt, 2);
    apb(SW_TRIGGER_OFF, 1'b0, 32'h0);
    chk("flush clear", rdat[1:0], 2'h0);
    $display("test flush done");
    startEv <= 1'b0;
    apb(EVENT_ROUTE_OFF, 1'b1, 32'h13);
    startEv <= 1'b1;
    wt(1'b0);
    repeat (10) @(negedge sys_clk);
    @(posedge sys_clk);
    syncEv <= 1'b1;
    repeat (200) @(negedge sys_clk);
    chk("sync restart", doneCnt, 3);
    $display("test events done");
    apb(INT_MASK_OFF, 1'b1, 32'h1);
    repeat (2) @(negedge sys_clk);
    chk("irq set", irq, 1'b1);
    apb(INT_STATUS_OFF, 1'b1, 32'h1);
    repeat (2) @(negedge sys_clk);
    chk("irq masked", irq, 1'b0);
    apb(INT_STATUS_OFF, 1'b0, 32'h0);
    chk("status", rdat[2:0], 3'h6);
    $display("test interrupts done");
    apb(SW_TRIGGER_OFF, 1'b1, 32'h2);
    wt(1'b0);
    @(posedge sys_clk);
    clkEn <= 1'b0;
    repeat (100) @(negedge sys_clk);
    chk("frozen active", convActive, 1'b1);
    chk("frozen done", doneCnt, 3);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    wt(1'b1);
    @(negedge sys_clk);
    chk("resumed done", doneCnt, 4);
    $display("test freeze done");
    final_report;
  end
endmodule
`default_nettype wire
